// [design/ecmd_pkg.sv]
package ecmd_pkg;

  // opcodes
  localparam logic [7:0] OP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_UNLOCK_DEF = 8'h06;
  localparam logic [7:0] OP_LOCK_DEF = 8'h04;
  localparam logic [7:0] OP_STATUS_DEF = 8'h05;
  localparam logic [7:0] OP_SLEEP_DEF = 8'hb9;
  localparam logic [7:0] OP_WAKE_DEF = 8'hab;

  // status byte layout
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LATCH_BIT = 1;
  localparam int STAT_SLEEP_BIT = 2;
  localparam int STAT_W = 3;
  localparam logic [4:0] STAT_PAD = 5'h00;

  // timing
  localparam int CLK_MHZ = 25;
  localparam int WAKEUP_DELAY_US = 75;
  localparam int TIMER_W = 20;
  localparam logic [TIMER_W-1:0] WAKEUP_CYCLES =
    TIMER_W'(WAKEUP_DELAY_US * CLK_MHZ);
  localparam logic [TIMER_W-1:0] ERASE_CYCLES_DEF = 20'h186a0;
  localparam logic [TIMER_W-1:0] TIMER_ONE = 20'h00001;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ERASE = 4'b0010,
    ST_SLEEP = 4'b0100,
    ST_WAKE = 4'b1000
  } state_t;

endpackage : ecmd_pkg

// [design/bit_sync.sv]
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // two-stage synchroniser; first stage feeds only the second
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end

endmodule : bit_sync

// [design/spi_frame_rx.sv]
module spi_frame_rx (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic rstn,
  input wire logic serial_in,
  input wire logic [2:0] stat_in,
  input wire logic [7:0] wake_op,
  input wire logic [7:0] status_op,
  output logic [7:0] first_op,
  output logic whole_bytes,
  output logic frame_tog,
  output logic wake_tog,
  output logic serial_out,
  output logic serial_out_oe
);

  logic [2:0] stat_s;
  logic active_q;
  logic reading_q;
  logic byte_seen_q;
  logic [2:0] bitcnt_q;
  logic [6:0] shreg_q;

  bit_sync #(.WIDTH(3)) u_stat_sync (
    .clk(sck),
    .d(stat_in),
    .q(stat_s)
  );

  wire [7:0] byte_now = {shreg_q, serial_in};
  wire last_bit = (bitcnt_q == 3'h7);
  wire first_byte = last_bit && !byte_seen_q;
  wire [7:0] stat_byte = {ecmd_pkg::STAT_PAD, stat_s};
  wire [2:0] out_idx = 3'h7 - bitcnt_q;

  // frame bookkeeping, cleared while chip select is high
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      active_q <= 1'b0;
      bitcnt_q <= 3'h0;
      byte_seen_q <= 1'b0;
      reading_q <= 1'b0;
    end else begin
      active_q <= 1'b1;
      bitcnt_q <= bitcnt_q + 3'h1;
      if (last_bit) begin
        byte_seen_q <= 1'b1;
      end
      // status read answers during erase, not in sleep
      if (first_byte && byte_now == status_op &&
          !stat_s[ecmd_pkg::STAT_SLEEP_BIT]) begin
        reading_q <= 1'b1;
      end
    end
  end

  // frame results held after chip select rises
  always_ff @(posedge sck) begin
    shreg_q <= byte_now[6:0];
    whole_bytes <= last_bit;
    if (first_byte) begin
      first_op <= byte_now;
    end
  end

  // event toggles toward the system clock
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      frame_tog <= 1'b0;
      wake_tog <= 1'b0;
    end else begin
      if (!active_q && !cs_n) begin
        frame_tog <= !frame_tog;
      end
      if (first_byte && byte_now == wake_op && !cs_n) begin
        wake_tog <= !wake_tog;
      end
    end
  end

  // status shifted out msb first at falling edges
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= reading_q;
      serial_out <= stat_byte[out_idx];
    end
  end

endmodule : spi_frame_rx

// [design/chip_erase_power_down_ctrl.sv]
module chip_erase_power_down_ctrl #(
  parameter logic [7:0] OP_UNLOCK = ecmd_pkg::OP_UNLOCK_DEF,
  parameter logic [7:0] OP_LOCK = ecmd_pkg::OP_LOCK_DEF,
  parameter logic [7:0] OP_STATUS = ecmd_pkg::OP_STATUS_DEF,
  parameter logic [7:0] OP_SLEEP = ecmd_pkg::OP_SLEEP_DEF,
  parameter logic [7:0] OP_WAKE = ecmd_pkg::OP_WAKE_DEF,
  parameter logic [19:0] ERASE_CYCLES = ecmd_pkg::ERASE_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  output logic busy_flag,
  output logic write_unlock_latch,
  output logic deep_sleep_entry,
  output logic device_awake,
  output logic array_fill_ones
);

  function automatic logic is_erase_op(input logic [7:0] op);
    is_erase_op = (op == ecmd_pkg::OP_ERASE_A) ||
                  (op == ecmd_pkg::OP_ERASE_B);
  endfunction : is_erase_op

  ecmd_pkg::state_t state_q;
  ecmd_pkg::state_t state_d;
  logic [19:0] timer_q;
  logic [19:0] timer_d;
  logic latch_q;
  logic latch_d;
  logic busy_q;
  logic sleep_q;
  logic awake_q;
  logic fill_q;
  logic cs_prev_q;
  logic frame_seen_q;
  logic wake_seen_q;
  logic [2:0] sync_s;
  logic [2:0] stat_q;
  logic [7:0] first_op;
  logic whole_bytes;
  logic frame_tog;
  logic wake_tog;
  logic rx_out;
  logic rx_oe;

  // link side: shifter, status out, event toggles
  spi_frame_rx u_rx (
    .sck(sck),
    .cs_n(cs_n),
    .rstn(rstn),
    .serial_in(serial_in),
    .stat_in(stat_q),
    .wake_op(OP_WAKE),
    .status_op(OP_STATUS),
    .first_op(first_op),
    .whole_bytes(whole_bytes),
    .frame_tog(frame_tog),
    .wake_tog(wake_tog),
    .serial_out(rx_out),
    .serial_out_oe(rx_oe)
  );

  // chip select and toggles into the system clock
  bit_sync #(.WIDTH(3)) u_sys_sync (
    .clk(clk_sys),
    .d({cs_n, frame_tog, wake_tog}),
    .q(sync_s)
  );

  wire cs_s = sync_s[2];
  wire frame_s = sync_s[1];
  wire wake_s = sync_s[0];

  // decode of a completed frame
  wire cs_rise = cs_s && !cs_prev_q;
  wire frame_new = frame_s != frame_seen_q;
  wire frame_exec = cs_rise && frame_new && whole_bytes;
  wire wake_evt = wake_s != wake_seen_q;
  wire in_idle = state_q == ecmd_pkg::ST_IDLE;
  wire op_unlock = frame_exec && first_op == OP_UNLOCK;
  wire op_lock = frame_exec && first_op == OP_LOCK;
  wire op_erase = frame_exec && is_erase_op(first_op);
  wire op_sleep = frame_exec && first_op == OP_SLEEP;
  wire erase_go = in_idle && op_erase && latch_q;
  wire sleep_go = in_idle && op_sleep;
  wire timer_end = timer_q == ecmd_pkg::TIMER_ONE;

  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    latch_d = latch_q;
    unique case (state_q)
      ecmd_pkg::ST_IDLE: begin
        if (erase_go) begin
          state_d = ecmd_pkg::ST_ERASE;
          timer_d = ERASE_CYCLES;
          latch_d = 1'b0;
        end else if (sleep_go) begin
          state_d = ecmd_pkg::ST_SLEEP;
          latch_d = 1'b0;
        end else if (op_lock) begin
          latch_d = 1'b0;
        end else if (op_unlock) begin
          latch_d = 1'b1;
        end
      end
      ecmd_pkg::ST_ERASE: begin
        // every frame but a status read ignored while busy
        timer_d = timer_q - ecmd_pkg::TIMER_ONE;
        if (timer_end) begin
          state_d = ecmd_pkg::ST_IDLE;
        end
      end
      ecmd_pkg::ST_SLEEP: begin
        if (wake_evt) begin
          state_d = ecmd_pkg::ST_WAKE;
          timer_d = ecmd_pkg::WAKEUP_CYCLES;
        end
      end
      ecmd_pkg::ST_WAKE: begin
        timer_d = timer_q - ecmd_pkg::TIMER_ONE;
        if (timer_end) begin
          state_d = ecmd_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = ecmd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= ecmd_pkg::ST_IDLE;
      timer_q <= '0;
      latch_q <= 1'b0;
      cs_prev_q <= 1'b1;
      frame_seen_q <= 1'b0;
      wake_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      latch_q <= latch_d;
      cs_prev_q <= cs_s;
      if (cs_rise) begin
        frame_seen_q <= frame_s;
      end
      wake_seen_q <= wake_s;
    end
  end

  // registered outputs and status toward the link
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      sleep_q <= 1'b0;
      awake_q <= 1'b1;
      fill_q <= 1'b0;
      stat_q <= '0;
    end else begin
      busy_q <= state_d == ecmd_pkg::ST_ERASE;
      fill_q <= state_d == ecmd_pkg::ST_ERASE;
      sleep_q <= state_d == ecmd_pkg::ST_SLEEP;
      awake_q <= (state_d == ecmd_pkg::ST_IDLE) ||
                 (state_d == ecmd_pkg::ST_ERASE);
      stat_q[ecmd_pkg::STAT_BUSY_BIT] <= state_d == ecmd_pkg::ST_ERASE;
      stat_q[ecmd_pkg::STAT_LATCH_BIT] <= latch_d;
      stat_q[ecmd_pkg::STAT_SLEEP_BIT] <= state_d == ecmd_pkg::ST_SLEEP;
    end
  end

  assign serial_out = rx_out;
  assign serial_out_oe = rx_oe;
  assign busy_flag = busy_q;
  assign write_unlock_latch = latch_q;
  assign deep_sleep_entry = sleep_q;
  assign device_awake = awake_q;
  assign array_fill_ones = fill_q;

  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence erase_start_s;
    $rose(busy_q);
  endsequence

  sequence wake_start_s;
    state_q == ecmd_pkg::ST_SLEEP && wake_evt;
  endsequence

  erase_fill_a: assert property (
    busy_q |-> array_fill_ones)
    else $error("array not filled with ones during erase");

  erase_latch_a: assert property (
    erase_start_s |-> $past(latch_q, 2) && !latch_q)
    else $error("erase started without unlock latch");

  erase_code_a: assert property (
    erase_start_s |-> is_erase_op($past(first_op, 2)))
    else $error("erase started by a wrong opcode");

  erase_edge_a: assert property (
    erase_start_s |-> $past(cs_rise))
    else $error("erase not started by chip select rise");

  erase_length_a: assert property (
    $rose(busy_q) |-> busy_q[*8])
    else $error("busy flag dropped too early");

  no_latch_a: assert property (
    in_idle && op_erase && !latch_q |=> state_q == ecmd_pkg::ST_IDLE)
    else $error("erase taken without unlock latch");

  sleep_enter_a: assert property (
    sleep_go |=> ##1 deep_sleep_entry && !write_unlock_latch)
    else $error("sleep not entered at chip select rise");

  sleep_hold_a: assert property (
    state_q == ecmd_pkg::ST_SLEEP && !wake_evt |=>
      state_q == ecmd_pkg::ST_SLEEP)
    else $error("sleep left without wakeup opcode");

  sleep_ignore_a: assert property (
    state_q == ecmd_pkg::ST_SLEEP |=> $stable(latch_q))
    else $error("command obeyed during sleep");

  wake_delay_a: assert property (
    wake_start_s |=> timer_q == ecmd_pkg::WAKEUP_CYCLES ##1
      !device_awake[*8])
    else $error("wakeup delay wrong");

  busy_ignore_a: assert property (
    state_q == ecmd_pkg::ST_ERASE |=> $stable(latch_q))
    else $error("command obeyed during erase");

  partial_a: assert property (
    cs_rise && !whole_bytes |=> $stable(latch_q))
    else $error("partial frame changed the latch");

  unlock_set_a: assert property (
    in_idle && op_unlock |=> write_unlock_latch)
    else $error("unlock frame did not set the latch");

  lock_clear_a: assert property (
    in_idle && op_lock |=> !write_unlock_latch)
    else $error("lock frame did not clear the latch");

  erase_clear_a: assert property (
    erase_go |=> !write_unlock_latch && state_q == ecmd_pkg::ST_ERASE)
    else $error("erase start left the latch set");

  sleep_clear_a: assert property (
    sleep_go |=> !write_unlock_latch && state_q == ecmd_pkg::ST_SLEEP)
    else $error("sleep entry left the latch set");

  erase_timer_a: assert property (
    erase_go |=> timer_q == ERASE_CYCLES)
    else $error("erase timer not loaded");

  erase_hold_a: assert property (
    state_q == ecmd_pkg::ST_ERASE && !timer_end |=>
      state_q == ecmd_pkg::ST_ERASE)
    else $error("erase cut short by a frame");

  erase_end_a: assert property (
    state_q == ecmd_pkg::ST_ERASE && timer_end |=>
      state_q == ecmd_pkg::ST_IDLE && !busy_flag)
    else $error("busy flag not cleared after erase");

  busy_nosleep_a: assert property (
    state_q == ecmd_pkg::ST_ERASE |=> !deep_sleep_entry)
    else $error("sleep entered during erase");

  sleep_busy_a: assert property (
    state_q == ecmd_pkg::ST_SLEEP |=> !busy_flag)
    else $error("erase started during sleep");

  wake_only_a: assert property (
    state_q == ecmd_pkg::ST_SLEEP && wake_evt |=>
      state_q == ecmd_pkg::ST_WAKE)
    else $error("wakeup opcode did not leave sleep");

  wake_hold_a: assert property (
    state_q == ecmd_pkg::ST_WAKE && !timer_end |=> !device_awake)
    else $error("device ready before wakeup delay");

  wake_ready_a: assert property (
    state_q == ecmd_pkg::ST_WAKE && timer_end |=>
      device_awake && state_q == ecmd_pkg::ST_IDLE)
    else $error("device not ready after wakeup delay");

endmodule : chip_erase_power_down_ctrl

// [tb/spi_host_model.sv]
module spi_host_model (
  output logic sck,
  output logic cs_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx_q;

  // brief low at start so the frame state sees a clean rise
  initial begin
    sck = 1'h0;
    cs_n = 1'h0;
    serial_in = 1'h0;
    rx_q = 8'h00;
    #1 cs_n = 1'h1;
  end

  // mode 0 frame, msb first, clock still between frames
  task automatic xfer(input logic [7:0] op, input int nbits);
    cs_n = 1'h0;
    for (int i = 0; i < nbits; i++) begin
      serial_in = (i < 8) ? op[7 - i] : ~serial_in;
      #7.5 sck = 1'h1;
      rx_q = {rx_q[6:0], serial_out & serial_out_oe};
      #7.5 sck = 1'h0;
    end
    #7.5 cs_n = 1'h1;
    serial_in = ~serial_in;
  endtask : xfer
endmodule : spi_host_model

// [tb/chip_erase_power_down_ctrl_tb_top.sv]
module chip_erase_power_down_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [19:0] ERASE_N = 20'h0003c;
  localparam logic [7:0] UNL = ecmd_pkg::OP_UNLOCK_DEF;
  localparam logic [7:0] LCK = ecmd_pkg::OP_LOCK_DEF;
  localparam logic [7:0] STS = ecmd_pkg::OP_STATUS_DEF;
  localparam logic [7:0] SLP = ecmd_pkg::OP_SLEEP_DEF;
  localparam logic [7:0] WAK = ecmd_pkg::OP_WAKE_DEF;
  localparam int WAKE_N = int'(ecmd_pkg::WAKEUP_CYCLES);
  logic clk_sys;
  logic rstn;
  wire logic sck, cs_n, serial_in, serial_out, serial_out_oe;
  logic busy_flag, write_unlock_latch, deep_sleep_entry;
  logic device_awake, array_fill_ones;
  int fail_count;
  int n_compared;

  chip_erase_power_down_ctrl #(.ERASE_CYCLES(ERASE_N)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .sck(sck), .cs_n(cs_n),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .busy_flag(busy_flag),
    .write_unlock_latch(write_unlock_latch),
    .deep_sleep_entry(deep_sleep_entry), .device_awake(device_awake),
    .array_fill_ones(array_fill_ones));

  spi_host_model host (.sck(sck), .cs_n(cs_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  initial clk_sys = 1'h0;
  always #20 clk_sys = ~clk_sys;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // {busy, latch, sleep, awake, fill}
  function automatic logic [7:0] st();
    return {3'h0, busy_flag, write_unlock_latch, deep_sleep_entry,
      device_awake, array_fill_ones};
  endfunction : st

  task automatic send(input logic [7:0] op, input int nbits);
    host.xfer(op, nbits);
    cyc(8);
  endtask : send

  task automatic t_partial();
    send(UNL, 7);
    chk("short unlock", 8'h02, st());
    send(UNL, 8);
    send(STS, 16);
    chk("status byte", 8'h02, host.rx_q);
    send(ecmd_pkg::OP_ERASE_A, 12);
    chk("short erase", 8'h0a, st());
    send(LCK, 8);
    chk("lock clears", 8'h02, st());
    send(ecmd_pkg::OP_ERASE_B, 8);
    chk("erase locked", 8'h02, st());
  endtask : t_partial

  task automatic t_erase(input logic [7:0] op);
    int n;
    send(UNL, 8);
    send(op, 8);
    chk("erase start", 8'h13, st());
    send(STS, 16);
    chk("busy status", 8'h01, host.rx_q);
    send(UNL, 8);
    chk("busy ignores", 8'h13, st());
    n = 0;
    while (busy_flag !== 1'h0 && n < 200) begin
      cyc(1);
      n++;
    end
    chk("erase end", 8'h02, st());
    if (n >= 200) begin
      fail_count++;
      stop_test();
    end
  endtask : t_erase

  task automatic t_sleep();
    int n;
    send(UNL, 8);
    send(SLP, 8);
    chk("sleep entry", 8'h04, st());
    send(UNL, 8);
    send(ecmd_pkg::OP_ERASE_A, 8);
    chk("sleep ignores", 8'h04, st());
    host.xfer(WAK, 9);
    n = 0;
    while (device_awake !== 1'h1 && n < 2100) begin
      cyc(1);
      n++;
    end
    chk("wake delay", 8'h01,
      8'((n >= WAKE_N - 1) && (n <= WAKE_N + 8)));
    if (n >= 2100) begin
      fail_count++;
      stop_test();
    end
    chk("awake state", 8'h02, st());
    cyc(8);
    send(UNL, 8);
    chk("ready again", 8'h0a, st());
  endtask : t_sleep

  initial begin
    rstn = 1'h1;
    fail_count = 0;
    n_compared = 0;
    #1 rstn = 1'h0;
    cyc(16);
    rstn = 1'h1;
    cyc(4);
    chk("reset state", 8'h02, st());
    t_partial();
    t_erase(ecmd_pkg::OP_ERASE_A);
    t_erase(ecmd_pkg::OP_ERASE_B);
    t_sleep();
    stop_test();
  end
endmodule : chip_erase_power_down_ctrl_tb_top
